// File: rtl/ipcb_regs.svh
// register offsets, field positions and reset values of the priority bank
`ifndef IPCB_REGS_SVH
`define IPCB_REGS_SVH

`define IPCB_ADDR_W         12
`define IPCB_DATA_W         32
`define IPCB_NUM_SRC        10
`define IPCB_NUM_REG        3
`define IPCB_NUM_LANE       4
`define IPCB_LANE_W         8
`define IPCB_CTRL3_LANES    2

`define IPCB_OFF_CTRL3      12'h000
`define IPCB_OFF_CTRL4      12'h004
`define IPCB_OFF_CTRL5      12'h008

`define IPCB_IDX_CTRL3      2'h0
`define IPCB_IDX_CTRL4      2'h1
`define IPCB_IDX_CTRL5      2'h2

`define IPCB_PRIO_LSB       2
`define IPCB_PRIO_W         3
`define IPCB_SUB_LSB        0
`define IPCB_SUB_W          2
`define IPCB_CFG_W          5

`define IPCB_CFG_RST        5'h00
`define IPCB_PRIO_OFF       3'h0
`define IPCB_RSVD_MASK      32'hE0E0E0E0
`define IPCB_CTRL3_RD_MASK  32'h00001F1F

`endif

// File: rtl/ipcb_pkg.sv
// types shared by the priority bank and its arbiter
package ipcb_pkg;
	typedef logic [2:0] ipcb_prio_t;
	typedef logic [1:0] ipcb_sub_t;
	typedef logic [4:0] ipcb_key_t;
	typedef logic [3:0] ipcb_id_t;
	typedef logic [1:0] ipcb_idx_t;
	typedef enum logic [3:0] {
		ipcb_src_timer3,
		ipcb_src_capture3,
		ipcb_src_timer4,
		ipcb_src_capture4,
		ipcb_src_compare_out4,
		ipcb_src_ext_irq4,
		ipcb_src_timer5,
		ipcb_src_capture5,
		ipcb_src_compare_out5,
		ipcb_src_serial_periph1
	} ipcb_src_t;
endpackage

// File: rtl/ipcb_arbiter.sv
// picks the pending source with the largest priority/subpriority key
`timescale 1ns/1ps
`include "ipcb_regs.svh"
module ipcb_arbiter (
	cand_valid,
	cand_key,
	win_valid,
	win_id,
	win_key
);
	input  wire logic [`IPCB_NUM_SRC-1:0]             cand_valid;
	input  wire logic [`IPCB_NUM_SRC*`IPCB_CFG_W-1:0] cand_key;
	output wire logic                                 win_valid;
	output ipcb_pkg::ipcb_id_t                        win_id;
	output ipcb_pkg::ipcb_key_t                       win_key;

	logic                [`IPCB_NUM_SRC:0] best_v;
	ipcb_pkg::ipcb_id_t                    best_id  [`IPCB_NUM_SRC+1];
	ipcb_pkg::ipcb_key_t                   best_key [`IPCB_NUM_SRC+1];

	assign best_v[0]   = 1'b0;
	assign best_id[0]  = 4'h0;
	assign best_key[0] = 5'h00;

	// strictly larger key replaces, so equal keys keep the lower source index
	genvar i;
	generate
		for (i = 0; i < `IPCB_NUM_SRC; i++) begin : g_chain
			wire ipcb_pkg::ipcb_key_t key_i = cand_key[i*`IPCB_CFG_W +: `IPCB_CFG_W];
			wire take = cand_valid[i] && (!best_v[i] || key_i > best_key[i]);
			assign best_v[i+1]   = best_v[i] | cand_valid[i];
			assign best_id[i+1]  = take ? 4'(i) : best_id[i];
			assign best_key[i+1] = take ? key_i : best_key[i];
		end
	endgenerate

	assign win_valid = best_v[`IPCB_NUM_SRC];
	assign win_id    = best_id[`IPCB_NUM_SRC];
	assign win_key   = best_key[`IPCB_NUM_SRC];
endmodule

// File: rtl/ipcb_top.sv
// interrupt priority bank: APB registers for ten sources and the winning request
//
// What this block does
// - priority code zero disables the source
// - nonzero priority code is the level itself
// - subpriority code is the sublevel itself
// - top lane: priority 28-26, subpriority 25-24
// - second lane: priority 20-18, subpriority 17-16
// - third lane: priority 12-10, subpriority 9-8
// - lowest lane: priority 4-2, subpriority 1-0
// - all fields read/write, zero after reset
// - register four: ext4, compare4, capture4, timer4
// - register five: serial1, compare5, capture5, timer5
// - register three low half: capture3, timer3
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ipcb_regs.svh"
module ipcb_top (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	pstrb,
	prdata,
	pready,
	pslverr,
	irq_pending,
	irq_req,
	irq_id,
	irq_level,
	irq_sublevel
);
	input  wire logic                     pclk;
	input  wire logic                     presetn;
	input  wire logic                     psel;
	input  wire logic                     penable;
	input  wire logic                     pwrite;
	input  wire logic [`IPCB_ADDR_W-1:0]  paddr;
	input  wire logic [`IPCB_DATA_W-1:0]  pwdata;
	input  wire logic [`IPCB_NUM_LANE-1:0] pstrb;
	output wire logic [`IPCB_DATA_W-1:0]  prdata;
	output wire logic                     pready;
	output wire logic                     pslverr;
	input  wire logic [`IPCB_NUM_SRC-1:0] irq_pending;
	output wire logic                     irq_req;
	output ipcb_pkg::ipcb_id_t            irq_id;
	output ipcb_pkg::ipcb_prio_t          irq_level;
	output ipcb_pkg::ipcb_sub_t           irq_sublevel;

	// address decode, used by the read path and the write path
	function automatic logic addr_hit(input logic [`IPCB_ADDR_W-1:0] a);
		addr_hit = (a == `IPCB_OFF_CTRL3) || (a == `IPCB_OFF_CTRL4) ||
			(a == `IPCB_OFF_CTRL5);
	endfunction

	function automatic ipcb_pkg::ipcb_idx_t addr_idx(input logic [`IPCB_ADDR_W-1:0] a);
		addr_idx = (a == `IPCB_OFF_CTRL5) ? `IPCB_IDX_CTRL5 :
			(a == `IPCB_OFF_CTRL4) ? `IPCB_IDX_CTRL4 : `IPCB_IDX_CTRL3;
	endfunction

	// source placement: register three holds two sources, four and five hold four each
	function automatic int src_reg(input int s);
		src_reg = (s < `IPCB_CTRL3_LANES) ? 0 : ((s - `IPCB_CTRL3_LANES) / `IPCB_NUM_LANE) + 1;
	endfunction

	function automatic int src_lane(input int s);
		src_lane = (s < `IPCB_CTRL3_LANES) ? s : (s - `IPCB_CTRL3_LANES) % `IPCB_NUM_LANE;
	endfunction

	// bus state
	logic                        pready_ff;
	logic                        pslverr_ff;
	logic [`IPCB_DATA_W-1:0]     prdata_ff;
	logic                        nxt_pready;
	logic                        nxt_pslverr;
	logic [`IPCB_DATA_W-1:0]     nxt_prdata;

	// per-source settings, bits 4-2 priority and 1-0 subpriority
	ipcb_pkg::ipcb_key_t         cfg_ff [`IPCB_NUM_SRC];

	// winner outputs
	logic                        irq_req_ff;
	ipcb_pkg::ipcb_id_t          irq_id_ff;
	ipcb_pkg::ipcb_prio_t        irq_level_ff;
	ipcb_pkg::ipcb_sub_t         irq_sublevel_ff;

	wire                         setup_w;
	wire                         wr_fire;
	wire                         rd_fire;
	wire ipcb_pkg::ipcb_idx_t    cur_idx;
	wire                         cur_hit;
	wire [`IPCB_DATA_W-1:0]      rd_acc [`IPCB_NUM_SRC+1];
	wire [`IPCB_NUM_SRC-1:0]     cand_valid;
	wire [`IPCB_NUM_SRC*`IPCB_CFG_W-1:0] cfg_flat;
	wire [`IPCB_NUM_SRC-1:0]     beats_w;
	wire                         win_valid;
	wire ipcb_pkg::ipcb_id_t     win_id;
	wire ipcb_pkg::ipcb_key_t    win_key;
	wire ipcb_pkg::ipcb_key_t    out_key;

	assign setup_w = psel && !penable;
	assign wr_fire = psel && penable && pready_ff && pwrite && !pslverr_ff;
	assign rd_fire = psel && penable && pready_ff && !pwrite;
	assign cur_idx = addr_idx(paddr);
	assign cur_hit = addr_hit(paddr);
	assign out_key = {irq_level_ff, irq_sublevel_ff};

	assign rd_acc[0] = 32'h00000000;

	genvar s;
	generate
		for (s = 0; s < `IPCB_NUM_SRC; s++) begin : g_src
			localparam int REG_I  = src_reg(s);
			localparam int LANE_I = src_lane(s);
			localparam int BASE_I = LANE_I * `IPCB_LANE_W;
			wire                      sel_w = (cur_idx == 2'(REG_I));
			wire                      wr_w  = wr_fire && sel_w && pstrb[LANE_I];
			// only the low five bits of a lane are stored, reserved bits are dropped
			wire ipcb_pkg::ipcb_key_t nxt_cfg = wr_w ? pwdata[BASE_I +: `IPCB_CFG_W] : cfg_ff[s];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_ff[s] <= `IPCB_CFG_RST;
				end else begin
					cfg_ff[s] <= nxt_cfg;
				end
			end

			// read word: the stored field placed back at its lane, zeros elsewhere
			assign rd_acc[s+1] = rd_acc[s] |
				(sel_w ? (32'(cfg_ff[s]) << BASE_I) : 32'h00000000);
			assign cfg_flat[s*`IPCB_CFG_W +: `IPCB_CFG_W] = cfg_ff[s];
			// a source with priority zero is never offered to the arbiter
			assign cand_valid[s] = irq_pending[s] &&
				(cfg_ff[s][`IPCB_PRIO_LSB +: `IPCB_PRIO_W] != `IPCB_PRIO_OFF);
			assign beats_w[s] = cand_valid[s] && (cfg_ff[s] > out_key);
		end
	endgenerate

	// zero-wait slave: ready rises in the first access cycle
	assign nxt_pready  = setup_w;
	assign nxt_pslverr = setup_w && !cur_hit;
	assign nxt_prdata  = (setup_w && !pwrite && cur_hit) ? rd_acc[`IPCB_NUM_SRC] : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	ipcb_arbiter u_arbiter (
		.cand_valid (cand_valid),
		.cand_key   (cfg_flat),
		.win_valid  (win_valid),
		.win_id     (win_id),
		.win_key    (win_key)
	);

	// the level and sublevel are the raw codes of the winning source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req_ff      <= 1'b0;
			irq_id_ff       <= 4'h0;
			irq_level_ff    <= 3'h0;
			irq_sublevel_ff <= 2'h0;
		end else begin
			irq_req_ff      <= win_valid;
			irq_id_ff       <= win_id;
			irq_level_ff    <= win_key[`IPCB_PRIO_LSB +: `IPCB_PRIO_W];
			irq_sublevel_ff <= win_key[`IPCB_SUB_LSB +: `IPCB_SUB_W];
		end
	end

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign irq_req      = irq_req_ff;
	assign irq_id       = irq_id_ff;
	assign irq_level    = irq_level_ff;
	assign irq_sublevel = irq_sublevel_ff;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wire ipcb_pkg::ipcb_key_t chosen_key = cfg_ff[irq_id_ff];

	all_off_quiet_a: assert property ((cand_valid == '0) |=> !irq_req_ff)
		else $error("request raised with no enabled pending source");
	level_is_code_a: assert property (irq_req_ff && $stable(cfg_flat) && $stable(irq_pending) |->
		irq_level_ff == chosen_key[4:2] && irq_level_ff != 3'h0)
		else $error("request level differs from winner priority code");
	sub_is_code_a: assert property (irq_req_ff && $stable(cfg_flat) && $stable(irq_pending) |->
		irq_sublevel_ff == chosen_key[1:0])
		else $error("request sublevel differs from winner subpriority code");
	rsvd_reads_zero_a: assert property (rd_fire |->
		(prdata_ff & `IPCB_RSVD_MASK) == 32'h00000000)
		else $error("reserved bits read nonzero");
	lane3_field_a: assert property (wr_fire && cur_idx == `IPCB_IDX_CTRL4 && pstrb[3] |=>
		cfg_ff[ipcb_pkg::ipcb_src_ext_irq4] == $past(pwdata[28:24]))
		else $error("top lane write did not land in external interrupt 4");
	lane2_field_a: assert property (wr_fire && cur_idx == `IPCB_IDX_CTRL5 && pstrb[2] |=>
		cfg_ff[ipcb_pkg::ipcb_src_compare_out5] == $past(pwdata[20:16]))
		else $error("second lane write did not land in compare 5");
	lane1_field_a: assert property (wr_fire && cur_idx == `IPCB_IDX_CTRL3 && pstrb[1] |=>
		cfg_ff[ipcb_pkg::ipcb_src_capture3] == $past(pwdata[12:8]))
		else $error("third lane write did not land in capture 3");
	lane0_field_a: assert property (wr_fire && cur_idx == `IPCB_IDX_CTRL4 && pstrb[0] |=>
		cfg_ff[ipcb_pkg::ipcb_src_timer4] == $past(pwdata[4:0]))
		else $error("lowest lane write did not land in timer 4");
	reset_clear_a: assert property ($rose(presetn) |->
		cfg_flat == '0 && !irq_req_ff)
		else $error("settings not cleared after reset");
	ctrl4_order_a: assert property (rd_fire && $past(cur_idx) == `IPCB_IDX_CTRL4 &&
		$stable(cfg_flat) |-> prdata_ff == {3'h0, cfg_ff[ipcb_pkg::ipcb_src_ext_irq4],
		3'h0, cfg_ff[ipcb_pkg::ipcb_src_compare_out4], 3'h0,
		cfg_ff[ipcb_pkg::ipcb_src_capture4], 3'h0, cfg_ff[ipcb_pkg::ipcb_src_timer4]})
		else $error("register four read order wrong");
	ctrl5_order_a: assert property (rd_fire && $past(cur_idx) == `IPCB_IDX_CTRL5 &&
		$stable(cfg_flat) |-> prdata_ff == {3'h0, cfg_ff[ipcb_pkg::ipcb_src_serial_periph1],
		3'h0, cfg_ff[ipcb_pkg::ipcb_src_compare_out5], 3'h0,
		cfg_ff[ipcb_pkg::ipcb_src_capture5], 3'h0, cfg_ff[ipcb_pkg::ipcb_src_timer5]})
		else $error("register five read order wrong");
	ctrl3_half_a: assert property (rd_fire && !pslverr_ff && $past(cur_idx) == `IPCB_IDX_CTRL3
		|-> (prdata_ff & ~`IPCB_CTRL3_RD_MASK) == 32'h00000000)
		else $error("register three upper half not zero");
	best_served_a: assert property (irq_req_ff && $stable(cfg_flat) && $stable(irq_pending) |->
		beats_w == '0)
		else $error("a better pending source was passed over");
	setup_answer_a: assert property (setup_w |=> pready_ff ##1 !pready_ff)
		else $error("slave ready not one access cycle");

	write_then_win_c: cover property (wr_fire ##[1:4] irq_req_ff);
	sub_tie_c: cover property (irq_req_ff && $countones(cand_valid) > 1 && irq_sublevel_ff != 2'h0);
	bad_addr_c: cover property (psel && penable && pslverr_ff);
	read_back_c: cover property (rd_fire && prdata_ff != 32'h00000000);
endmodule

// File: sim/irq_priority_config_bank_tb.sv
// self-checking bench for the interrupt priority bank
`timescale 1ns/1ps
`include "ipcb_regs.svh"
module irq_priority_config_bank_tb;
	typedef struct {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
		logic [31:0] rexp;
	} ipcb_wrow_t;
	typedef struct {
		logic [9:0] pend;
		logic [9:0] exp;
	} ipcb_irow_t;

	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [3:0]           pstrb;
	wire logic [31:0]     prdata;
	wire logic            pready;
	wire logic            pslverr;
	logic [9:0]           irq_pending;
	wire logic            irq_req;
	ipcb_pkg::ipcb_id_t   irq_id;
	ipcb_pkg::ipcb_prio_t irq_level;
	ipcb_pkg::ipcb_sub_t  irq_sublevel;
	int                   miscompares;
	int                   checks;
	logic [31:0]          rd;
	logic                 err;
	ipcb_wrow_t           wrows [4];
	ipcb_irow_t           irows [6];

	ipcb_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_pending(irq_pending), .irq_req(irq_req), .irq_id(irq_id),
		.irq_level(irq_level), .irq_sublevel(irq_sublevel)
	);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic complete_run();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits for pready with a bounded count
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// winner outputs packed as {req, id, level, sublevel}
	task automatic irq_chk(input logic [9:0] pend, input logic [9:0] exp);
		@(posedge pclk);
		irq_pending <= pend;
		repeat (3) @(posedge pclk);
		#1;
		chk({22'h0, irq_req, irq_id, irq_level, irq_sublevel}, {22'h0, exp});
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		irq_pending = 10'h000;
		miscompares = 0;
		checks = 0;
		wrows[0] = '{`IPCB_OFF_CTRL4, 32'h1F1F1F1F, 4'hF, 32'h1F1F1F1F};
		wrows[1] = '{`IPCB_OFF_CTRL3, 32'h1F1F1F1F, 4'hF, 32'h00001F1F};
		wrows[2] = '{`IPCB_OFF_CTRL5, 32'h05050505, 4'hF, 32'h05050505};
		wrows[3] = '{`IPCB_OFF_CTRL4, 32'h12141618, 4'h5, 32'h1F141F18};
		irows[0] = '{10'h000, 10'h000};
		irows[1] = '{10'h010, {1'b1, 4'h4, 3'h5, 2'h0}};
		irows[2] = '{10'h014, {1'b1, 4'h2, 3'h6, 2'h0}};
		irows[3] = '{10'h02A, {1'b1, 4'h1, 3'h7, 2'h3}};
		irows[4] = '{10'h240, {1'b1, 4'h6, 3'h1, 2'h1}};
		irows[5] = '{10'h200, {1'b1, 4'h9, 3'h1, 2'h1}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 12'h00C, 32'h0, 4'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, wrows[i].addr, wrows[i].wdata, wrows[i].strb);
			apb(1'b0, wrows[i].addr, 32'h0, 4'h0);
			chk(rd, wrows[i].rexp);
			chk({31'h0, err}, 32'h0);
		end
		for (int i = 0; i < 6; i++) begin
			irq_chk(irows[i].pend, irows[i].exp);
		end
		// equal level: the higher subpriority wins even from a higher index
		apb(1'b1, `IPCB_OFF_CTRL5, 32'h0E0D030C, 4'hF);
		irq_chk(10'h3C0, {1'b1, 4'h9, 3'h3, 2'h2});
		irq_chk(10'h140, {1'b1, 4'h8, 3'h3, 2'h1});
		irq_chk(10'h080, 10'h000);
		irq_chk(10'h3FF, {1'b1, 4'h0, 3'h7, 2'h3});
		// second reset in mid-run clears settings and winner outputs
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		chk({22'h0, irq_req, irq_id, irq_level, irq_sublevel}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		irq_chk(10'h3FF, 10'h000);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
			chk(rd, 32'h0);
		end
		complete_run();
	end
endmodule
